//--- rtl/exs_consts.svh
/*
 * Constants for the exception sequencer: vector offsets, reset values, timing.
 * Assumes inclusion by bare name from rtl/ and tb/ sources.
 */
`ifndef EXS_CONSTS_SVH
`define EXS_CONSTS_SVH

// ****************************************
// Reset entry
// ****************************************
`define EXS_RESET_PC_ADDR     32'ha0000000
`define EXS_RESET_SP_ADDR     32'ha0000004
`define EXS_VBR_RESET         32'h00000000
`define EXS_MASK_RESET        4'hf
`define EXS_NMI_MASK_LOAD     4'hf

// ****************************************
// Levels and stacking
// ****************************************
`define EXS_LEVEL_NMI         5'h10
`define EXS_LEVEL_FIXED       5'h0f
`define EXS_STACK_STEP        32'h00000004

// ****************************************
// Vector offsets (byte offsets from the vector base)
// ****************************************
`define EXS_VOFS_ILLEGAL      32'h00000010
`define EXS_VOFS_SLOT         32'h00000018
`define EXS_VOFS_ADDR_ERR     32'h00000024
`define EXS_VOFS_NMI          32'h0000002c
`define EXS_VOFS_UBREAK       32'h00000030
`define EXS_VOFS_DEBUG        32'h0000002c

// ****************************************
// Status word field
// ****************************************
`define EXS_SR_MASK_LSB       4
`define EXS_SR_MASK_MSB       7

// ****************************************
// Reset pin low time
// ****************************************
`define EXS_RESET_MIN_TCYC    20

`endif

//--- rtl/exs_pkg.sv
/*
 * Types shared by the exception sequencer files.
 * Assumes exs_consts.svh is available on the include path.
 */
`default_nettype none

package exs_pkg;

	typedef enum logic [3:0] {
		EXS_IDLE,
		EXS_RESET_HOLD,
		EXS_FETCH_PC,
		EXS_FETCH_SP,
		EXS_WAIT_RETIRE,
		EXS_PUSH_SR,
		EXS_PUSH_PC,
		EXS_FETCH_VEC,
		EXS_BRANCH
	} exs_state_e;

	typedef enum logic [2:0] {
		EXS_SRC_NONE,
		EXS_SRC_ADDR_ERR,
		EXS_SRC_INTR,
		EXS_SRC_TRAP,
		EXS_SRC_SLOT,
		EXS_SRC_ILLEGAL
	} exs_src_e;

	// Bus request toward the bus unit
	typedef struct packed {
		logic        req;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} exs_bus_req_s;

	// Pipeline exception report
	typedef struct packed {
		logic        addr_err;
		logic        trap;
		logic        undef_op;
		logic        pc_change_op;
		logic        in_slot;
		logic [7:0]  trap_vec;
		logic [31:0] inst_pc;
		logic [31:0] next_pc;
		logic [31:0] branch_pc;
		logic [31:0] branch_target;
	} exs_pipe_s;

	// Winning interrupt from the priority arbiter
	typedef struct packed {
		logic        valid;
		logic        nmi;
		logic [4:0]  level;
		logic [31:0] vec_ofs;
	} exs_intr_s;

endpackage : exs_pkg

`default_nettype wire

//--- rtl/exs_sync2.sv
/*
 * Two-stage synchroniser for asynchronous level inputs.
 * Assumes one clock and a synchronous active-high reset.
 */
`default_nettype none

module exs_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clock_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] reset_val_in,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	if (WIDTH < 1) begin : g_bad_width
		$error("exs_sync2: WIDTH must be at least 1");
	end

	// Reset values come from constants tied at the instance
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			meta_r   <= reset_val_in;
			sync_out <= reset_val_in;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule // exs_sync2

`default_nettype wire

//--- rtl/exs_sequencer.sv
/*
 * Exception sequencer: reset entry, address error, interrupt, trap and
 * illegal-instruction handling with stacking and vector fetch.
 * Assumes a bus unit that answers each request with a one-cycle ack, a
 * pipeline that stalls while busy_out is high, and a priority arbiter that
 * presents its single winning request.
 */
// Function
// - Reset beats every other pending exception
// - Pin low holds power-on reset, initializes state
// - On release fetch PC, then SP, start
// - Reset clears vector base, mask to ones
// - Armed watchdog overflow triggers same reset
// - Simultaneous pin and watchdog: clear overflow flag
// - Debug port reset command runs same sequence
// - Address error waits for instruction finish
// - Address error pushes status, then faulting PC
// - Fetch handler vector, branch without slot
// - Levels zero to sixteen, NMI unmaskable
// - User break and debug fixed level fifteen
// - Other interrupts levels zero to fifteen only
// - Maskable accepted only above mask bits
// - Interrupt stacks, loads level; NMI loads fifteen
// - Trap stacks next PC, vectors by number
// - Slot illegal stacks branch target address
// - General illegal stacks undefined code address
// - Arbiter resolves simultaneous interrupts by level
// - Reset PC and SP from fixed vectors
// - Non-interrupt exceptions keep mask bits
// - Each push predecrements stack pointer four
`default_nettype none
`include "exs_consts.svh"

module exs_sequencer
	import exs_pkg::*;
(
	// Clock and reset
	input  wire logic         clock_in,
	input  wire logic         rst_in,
	// Reset sources
	input  wire logic         power_on_init_pin_n_in,
	input  wire logic         watchdog_overflow_in,
	input  wire logic         watchdog_reset_en_in,
	input  wire logic         debug_port_reset_in,
	output logic              watchdog_overflow_flag_clr_out,
	// Pipeline
	input  wire exs_pkg::exs_pipe_s pipe_in,
	input  wire logic         inst_retired_in,
	input  wire logic [31:0]  sp_in,
	input  wire logic [31:0]  status_word_in,
	output logic              busy_out,
	output logic              init_state_out,
	// Interrupt arbiter
	input  wire exs_pkg::exs_intr_s intr_in,
	output logic              intr_ack_out,
	// Bus unit
	output exs_pkg::exs_bus_req_s bus_out,
	input  wire logic         bus_ack_in,
	input  wire logic [31:0]  bus_rdata_in,
	// Architectural updates
	output logic              load_pc_out,
	output logic [31:0]       new_pc_out,
	output logic              load_sp_out,
	output logic [31:0]       new_sp_out,
	output logic [31:0]       vector_base_out,
	output logic [3:0]        interrupt_mask_bits_out,
	output logic              mask_load_out,
	output logic [31:0]       status_word_out
);
	import exs_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		exs_state_e  state;
		exs_src_e    src;
		logic [31:0] sp;
		logic [31:0] save_pc;
		logic [31:0] save_sr;
		logic [31:0] vec_addr;
		logic [31:0] vbase;
		logic [3:0]  mask;
		logic [3:0]  new_mask;
		logic        mask_upd;
		logic        wdt_clr;
		logic        ld_pc;
		logic        ld_sp;
		logic        mask_ld;
		logic [31:0] pc_val;
		logic [31:0] sp_val;
		exs_bus_req_s bus;
	} exs_regs_s;

	exs_regs_s st_r;
	exs_regs_s st_nxt;

	logic pin_n_sync;
	logic wdt_ovf_sync;
	logic dbg_rst_sync;
	logic wdt_ovf_d_r;
	logic dbg_rst_d_r;

	// ****************************************
	// Input synchronisers
	// ****************************************
	exs_sync2 #(.WIDTH(3)) u_sync (
		.clock_in     (clock_in),
		.rst_in       (rst_in),
		.reset_val_in (3'h0), // Pin reads low, so hold outlives rst_in
		.async_in     ({watchdog_overflow_in, debug_port_reset_in, power_on_init_pin_n_in}),
		.sync_out     ({wdt_ovf_sync, dbg_rst_sync, pin_n_sync})
	);

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			wdt_ovf_d_r <= 1'b0;
			dbg_rst_d_r <= 1'b0;
		end else begin
			wdt_ovf_d_r <= wdt_ovf_sync;
			dbg_rst_d_r <= dbg_rst_sync;
		end
	end

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] vec_of(input logic [31:0] base, input logic [31:0] ofs);
		vec_of = base + ofs;
	endfunction

	function automatic exs_bus_req_s rd_req(input logic [31:0] a);
		rd_req = '{req: 1'b1, write: 1'b0, addr: a, wdata: 32'h0};
	endfunction

	function automatic exs_bus_req_s wr_req(input logic [31:0] a, input logic [31:0] d);
		wr_req = '{req: 1'b1, write: 1'b1, addr: a, wdata: d};
	endfunction

	// Level of a presented interrupt: NMI forced to 16, others clipped to 15
	function automatic logic [4:0] eff_level(input exs_intr_s i);
		if (i.nmi) begin
			eff_level = `EXS_LEVEL_NMI;
		end else if (i.level > `EXS_LEVEL_FIXED) begin
			eff_level = `EXS_LEVEL_FIXED;
		end else begin
			eff_level = i.level;
		end
	endfunction

	logic wdt_event;
	logic dbg_event;
	logic pin_low;
	logic intr_take;
	logic [4:0] lvl;
	logic [3:0] sw_mask;

	always_comb begin
		pin_low   = ~pin_n_sync;
		wdt_event = wdt_ovf_sync & ~wdt_ovf_d_r & watchdog_reset_en_in;
		dbg_event = dbg_rst_sync & ~dbg_rst_d_r;
		lvl       = eff_level(intr_in);
		// Live status word mask, so software can lower it again
		sw_mask   = status_word_in[`EXS_SR_MASK_MSB:`EXS_SR_MASK_LSB];
		// Unmaskable NMI, others strictly above mask
		intr_take = intr_in.valid & (intr_in.nmi | (lvl > {1'b0, sw_mask}));
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		st_nxt         = st_r;
		st_nxt.wdt_clr = 1'b0;
		st_nxt.ld_pc   = 1'b0;
		st_nxt.ld_sp   = 1'b0;
		st_nxt.mask_ld = 1'b0;
		intr_ack_out   = 1'b0;

		if (pin_low) begin
			// Pin holds everything in reset; wins over all others
			st_nxt.state    = EXS_RESET_HOLD;
			st_nxt.bus      = '0;
			st_nxt.vbase    = `EXS_VBR_RESET;
			st_nxt.mask     = `EXS_MASK_RESET;
			st_nxt.src      = EXS_SRC_NONE;
			st_nxt.wdt_clr  = wdt_ovf_sync;
		end else if (wdt_event | dbg_event) begin
			st_nxt.state = EXS_FETCH_PC;
			st_nxt.bus   = rd_req(`EXS_RESET_PC_ADDR);
			st_nxt.src   = EXS_SRC_NONE;
		end else begin
			case (st_r.state)
				EXS_RESET_HOLD: begin
					st_nxt.state = EXS_FETCH_PC;
					st_nxt.bus   = rd_req(`EXS_RESET_PC_ADDR);
				end
				EXS_FETCH_PC: begin
					if (bus_ack_in) begin
						st_nxt.pc_val = bus_rdata_in;
						st_nxt.state  = EXS_FETCH_SP;
						st_nxt.bus    = rd_req(`EXS_RESET_SP_ADDR);
					end
				end
				EXS_FETCH_SP: begin
					if (bus_ack_in) begin
						st_nxt.sp_val  = bus_rdata_in;
						st_nxt.bus     = '0;
						st_nxt.vbase   = `EXS_VBR_RESET;
						st_nxt.mask    = `EXS_MASK_RESET;
						st_nxt.mask_ld = 1'b1;
						st_nxt.ld_pc   = 1'b1;
						st_nxt.ld_sp   = 1'b1;
						st_nxt.state   = EXS_IDLE;
					end
				end
				EXS_IDLE: begin
					st_nxt.sp      = sp_in;
					st_nxt.save_sr = status_word_in;
					st_nxt.mask_upd = 1'b0;
					// Fixed priority among non-reset sources
					if (pipe_in.addr_err) begin
						st_nxt.src = EXS_SRC_ADDR_ERR;
						// Delay-slot fault reports the branch
						st_nxt.save_pc  = pipe_in.in_slot ? pipe_in.branch_pc : pipe_in.inst_pc;
						st_nxt.vec_addr = vec_of(st_r.vbase, `EXS_VOFS_ADDR_ERR);
						st_nxt.state    = EXS_WAIT_RETIRE;
					end else if (pipe_in.in_slot & (pipe_in.undef_op | pipe_in.pc_change_op)) begin
						st_nxt.src      = EXS_SRC_SLOT;
						st_nxt.save_pc  = pipe_in.branch_target;
						st_nxt.vec_addr = vec_of(st_r.vbase, `EXS_VOFS_SLOT);
						st_nxt.state    = EXS_PUSH_SR;
					end else if (pipe_in.undef_op) begin
						st_nxt.src      = EXS_SRC_ILLEGAL;
						st_nxt.save_pc  = pipe_in.inst_pc;
						st_nxt.vec_addr = vec_of(st_r.vbase, `EXS_VOFS_ILLEGAL);
						st_nxt.state    = EXS_PUSH_SR;
					end else if (pipe_in.trap) begin
						st_nxt.src      = EXS_SRC_TRAP;
						st_nxt.save_pc  = pipe_in.next_pc;
						// Vector number times four
						st_nxt.vec_addr = vec_of(st_r.vbase, {22'h0, pipe_in.trap_vec, 2'h0});
						st_nxt.state    = EXS_PUSH_SR;
					end else if (intr_take) begin
						intr_ack_out    = 1'b1;
						st_nxt.src      = EXS_SRC_INTR;
						st_nxt.save_pc  = pipe_in.inst_pc;
						st_nxt.vec_addr = vec_of(st_r.vbase, intr_in.vec_ofs);
						// NMI loads 15, not 16
						st_nxt.new_mask = intr_in.nmi ? `EXS_NMI_MASK_LOAD : lvl[3:0];
						st_nxt.mask_upd = 1'b1;
						st_nxt.state    = EXS_PUSH_SR;
					end
					if (st_nxt.state == EXS_PUSH_SR) begin
						st_nxt.sp  = sp_in - `EXS_STACK_STEP;
						st_nxt.bus = wr_req(sp_in - `EXS_STACK_STEP, status_word_in);
					end
				end
				EXS_WAIT_RETIRE: begin
					if (inst_retired_in) begin
						st_nxt.sp    = st_r.sp - `EXS_STACK_STEP;
						st_nxt.bus   = wr_req(st_r.sp - `EXS_STACK_STEP, st_r.save_sr);
						st_nxt.state = EXS_PUSH_SR;
					end
				end
				EXS_PUSH_SR: begin
					if (bus_ack_in) begin
						// Status first, then PC
						st_nxt.sp    = st_r.sp - `EXS_STACK_STEP;
						st_nxt.bus   = wr_req(st_r.sp - `EXS_STACK_STEP, st_r.save_pc);
						st_nxt.state = EXS_PUSH_PC;
					end
				end
				EXS_PUSH_PC: begin
					if (bus_ack_in) begin
						st_nxt.bus   = rd_req(st_r.vec_addr);
						st_nxt.state = EXS_FETCH_VEC;
					end
				end
				EXS_FETCH_VEC: begin
					if (bus_ack_in) begin
						st_nxt.bus    = '0;
						st_nxt.pc_val = bus_rdata_in;
						st_nxt.sp_val = st_r.sp;
						st_nxt.ld_pc  = 1'b1;
						st_nxt.ld_sp  = 1'b1;
						if (st_r.mask_upd) begin
							st_nxt.mask    = st_r.new_mask;
							st_nxt.mask_ld = 1'b1;
						end
						st_nxt.state = EXS_BRANCH;
					end
				end
				EXS_BRANCH: begin
					// Redirect is direct: no delay slot follows
					st_nxt.state = EXS_IDLE;
				end
				default: begin
					st_nxt.state = EXS_RESET_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st_r       <= '0;
			st_r.state <= EXS_RESET_HOLD;
			st_r.src   <= EXS_SRC_NONE;
			st_r.mask  <= `EXS_MASK_RESET;
			st_r.vbase <= `EXS_VBR_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb begin
		watchdog_overflow_flag_clr_out = st_r.wdt_clr;
		busy_out                = (st_r.state != EXS_IDLE);
		init_state_out          = (st_r.state == EXS_RESET_HOLD);
		bus_out                 = st_r.bus;
		load_pc_out             = st_r.ld_pc;
		new_pc_out              = st_r.pc_val;
		load_sp_out             = st_r.ld_sp;
		new_sp_out              = st_r.sp_val;
		vector_base_out         = st_r.vbase;
		interrupt_mask_bits_out = st_r.mask;
		mask_load_out           = st_r.mask_ld;
		status_word_out         = status_word_in;
		status_word_out[`EXS_SR_MASK_MSB:`EXS_SR_MASK_LSB] = st_r.mask;
	end

endmodule // exs_sequencer

`default_nettype wire

//--- tb/exs_sequencer_asserts.sv
/*
 * Concurrent checks on the exception sequencer ports.
 * Assumes one clock and synchronous active-high reset; bound below.
 */
`default_nettype none

module exs_sequencer_asserts
	import exs_pkg::*;
(
	// Clock, reset, reset sources
	input  wire logic                  clock_in,
	input  wire logic                  rst_in,
	input  wire logic                  power_on_init_pin_n_in,
	input  wire logic                  watchdog_overflow_in,
	input  wire logic                  watchdog_reset_en_in,
	input  wire logic                  debug_port_reset_in,
	input  wire logic                  watchdog_overflow_flag_clr_out,
	// Pipeline and arbiter
	input  wire exs_pkg::exs_pipe_s    pipe_in,
	input  wire logic [31:0]           sp_in,
	input  wire logic [31:0]           status_word_in,
	input  wire logic                  busy_out,
	input  wire logic                  init_state_out,
	input  wire exs_pkg::exs_intr_s    intr_in,
	input  wire logic                  intr_ack_out,
	// Bus and updates
	input  wire exs_pkg::exs_bus_req_s bus_out,
	input  wire logic                  bus_ack_in,
	input  wire logic [31:0]           bus_rdata_in,
	input  wire logic                  load_pc_out,
	input  wire logic [31:0]           new_pc_out,
	input  wire logic [3:0]            interrupt_mask_bits_out,
	input  wire logic                  mask_load_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	// Last non-SP read word and last accepted level
	logic [31:0] rd_r;
	logic [3:0]  lvl_r;
	always_ff @(posedge clock_in) begin
		if (bus_out.req && bus_ack_in && !bus_out.write && bus_out.addr != 32'ha0000004)
			rd_r <= bus_rdata_in;
		// Every reset loads all ones
		if (rst_in || (bus_out.req && bus_ack_in && !bus_out.write
				&& bus_out.addr == 32'ha0000004))
			lvl_r <= 4'hf;
		else if (intr_ack_out)
			lvl_r <= (intr_in.nmi || intr_in.level > 5'h0f) ? 4'hf : intr_in.level[3:0];
	end

	property p_pin_hold;
		!power_on_init_pin_n_in [*4] |-> init_state_out && busy_out && !bus_out.req;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin low but not held");
	property p_rst_pc;
		$fell(init_state_out) |-> ##[0:1] (bus_out.req && !bus_out.write && bus_out.addr == 32'ha0000000);
	endproperty
	a_rst_pc: assert property (p_rst_pc) else $error("no pc fetch after hold");
	property p_rst_sp;
		bus_out.req && !bus_out.write && bus_ack_in && bus_out.addr == 32'ha0000000
			|-> ##[1:2] (bus_out.req && !bus_out.write && bus_out.addr == 32'ha0000004);
	endproperty
	a_rst_sp: assert property (p_rst_sp) else $error("no sp fetch after pc");
	property p_push_addr;
		bus_out.req && bus_out.write |-> bus_out.addr == sp_in - 32'h4 || bus_out.addr == sp_in - 32'h8;
	endproperty
	a_push_addr: assert property (p_push_addr) else $error("push address wrong");
	property p_push_order;
		bus_out.req && bus_out.write && bus_ack_in && bus_out.addr == sp_in - 32'h4
			|-> ##[1:2] (bus_out.req && bus_out.write && bus_out.addr == sp_in - 32'h8);
	endproperty
	a_push_order: assert property (p_push_order) else $error("second push missing");
	property p_intr_ack;
		intr_ack_out |-> intr_in.valid
			&& (intr_in.nmi || intr_in.level > {1'b0, status_word_in[7:4]})
			&& (intr_in.nmi || status_word_in[7:4] != 4'hf);
	endproperty
	a_intr_ack: assert property (p_intr_ack) else $error("interrupt taken at or below mask");
	property p_mask_load;
		mask_load_out |-> ##[0:1] interrupt_mask_bits_out == lvl_r;
	endproperty
	a_mask_load: assert property (p_mask_load) else $error("mask not loaded with level");
	property p_mask_keep;
		!(mask_load_out || $past(mask_load_out) || init_state_out || $past(init_state_out))
			|-> $stable(interrupt_mask_bits_out);
	endproperty
	a_mask_keep: assert property (p_mask_keep) else $error("mask changed without load");
	property p_branch;
		load_pc_out |-> new_pc_out == rd_r;
	endproperty
	a_branch: assert property (p_branch) else $error("branch target not fetched word");
	property p_aerr_wait;
		pipe_in.addr_err && !busy_out |=> busy_out && !bus_out.req;
	endproperty
	a_aerr_wait: assert property (p_aerr_wait) else $error("stacking before retire");
	property p_wdt;
		$rose(watchdog_overflow_in) && watchdog_reset_en_in && power_on_init_pin_n_in && !busy_out
			|-> ##[1:6] (bus_out.req && !bus_out.write && bus_out.addr == 32'ha0000000);
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset not started");
	property p_dbg;
		$rose(debug_port_reset_in) && power_on_init_pin_n_in && !busy_out
			|-> ##[1:6] (bus_out.req && !bus_out.write && bus_out.addr == 32'ha0000000);
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug reset not started");
	property p_wdt_clr;
		// Two sync stages plus the register: three cycles behind the pins
		watchdog_overflow_flag_clr_out
			|-> $past(watchdog_overflow_in, 3) && !$past(power_on_init_pin_n_in, 3);
	endproperty
	a_wdt_clr: assert property (p_wdt_clr) else $error("flag clear without overflow");
endmodule // exs_sequencer_asserts

bind exs_sequencer exs_sequencer_asserts i_exs_sequencer_asserts (
	.clock_in(clock_in), .rst_in(rst_in), .power_on_init_pin_n_in(power_on_init_pin_n_in),
	.watchdog_overflow_in(watchdog_overflow_in), .watchdog_reset_en_in(watchdog_reset_en_in),
	.debug_port_reset_in(debug_port_reset_in), .pipe_in(pipe_in), .sp_in(sp_in),
	.status_word_in(status_word_in),
	.watchdog_overflow_flag_clr_out(watchdog_overflow_flag_clr_out), .busy_out(busy_out),
	.init_state_out(init_state_out), .intr_in(intr_in), .intr_ack_out(intr_ack_out),
	.bus_out(bus_out), .bus_ack_in(bus_ack_in), .bus_rdata_in(bus_rdata_in),
	.load_pc_out(load_pc_out), .new_pc_out(new_pc_out), .mask_load_out(mask_load_out),
	.interrupt_mask_bits_out(interrupt_mask_bits_out)
);

`default_nettype wire

//--- tb/exs_bus_model.sv
/*
 * Bus unit and memory model: acks each request after 0..3 wait cycles.
 * Assumes requests that hold until acked.
 */
`default_nettype none

module exs_bus_model
	import exs_pkg::*;
(
	// Clock and reset
	input  wire logic                  clock_in,
	input  wire logic                  rst_in,
	// Request
	input  wire exs_pkg::exs_bus_req_s bus_in,
	input  wire logic [1:0]            slow_in,
	// Answer
	output logic                       ack_out,
	output logic [31:0]                rdata_out,
	output logic [1:0][31:0]           wlog_out
);
	logic [1:0]  wait_r;
	logic [31:0] word;
	assign word = bus_in.addr ^ 32'h0f0f0f00;
	// Data lines never show a stale word outside the ack cycle
	assign rdata_out = ack_out ? word : ~word;
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			ack_out <= 1'b0;
			wait_r  <= 2'h0;
		end else if (ack_out || !bus_in.req) begin
			ack_out <= 1'b0;
			wait_r  <= slow_in;
		end else if (wait_r != 2'h0) begin
			wait_r <= wait_r - 2'h1;
		end else begin
			ack_out <= 1'b1;
			if (bus_in.write)
				wlog_out <= {wlog_out[0], bus_in.wdata};
		end
	end
endmodule // exs_bus_model

`default_nettype wire

//--- tb/cpu_exception_sequencer_test.sv
/*
 * Self-checking bench for the exception sequencer.
 * Assumes exs_bus_model as bus unit and the bound checker.
 */
`default_nettype none
`include "exs_consts.svh"

module cpu_exception_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;
	import exs_pkg::*;
	logic clock_in, rst_in, pin_n, wdt_ov, wdt_en, dbg, clr, retired, busy, init, iack;
	logic load_pc, load_sp, mload, ack, seen, take;
	logic [31:0] sp, sw, sw_out, rdata, new_pc, new_sp, vbase, seed, v;
	logic [63:0] e;
	logic [3:0] mask, em;
	logic [1:0] slow;
	logic [1:0][31:0] wlog;
	exs_pipe_s pipe, p;
	exs_intr_s intr;
	exs_bus_req_s bus;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	// Flag codes {addr_err, trap, undef, pc_change, in_slot}
	logic [4:0] codes[8] = '{5'h08, 5'h05, 5'h03, 5'h04, 5'h10, 5'h11, 5'h14, 5'h0c};

	exs_sequencer i_exs_sequencer (.clock_in(clock_in), .rst_in(rst_in),
		.power_on_init_pin_n_in(pin_n), .watchdog_overflow_in(wdt_ov),
		.watchdog_reset_en_in(wdt_en), .debug_port_reset_in(dbg),
		.watchdog_overflow_flag_clr_out(clr), .pipe_in(pipe), .inst_retired_in(retired),
		.sp_in(sp), .status_word_in(sw), .busy_out(busy), .init_state_out(init),
		.intr_in(intr), .intr_ack_out(iack), .bus_out(bus), .bus_ack_in(ack),
		.bus_rdata_in(rdata), .load_pc_out(load_pc), .new_pc_out(new_pc),
		.load_sp_out(load_sp), .new_sp_out(new_sp), .vector_base_out(vbase),
		.interrupt_mask_bits_out(mask), .mask_load_out(mload), .status_word_out(sw_out));
	exs_bus_model i_exs_bus_model (.clock_in(clock_in), .rst_in(rst_in), .bus_in(bus),
		.slow_in(slow), .ack_out(ack), .rdata_out(rdata), .wlog_out(wlog));

	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end

	task automatic finish_test();
		if (n_mismatch == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, x);
		end
	endtask

	function automatic logic [31:0] mem(input logic [31:0] a);
		return a ^ 32'h0f0f0f00;
	endfunction

	function automatic logic [63:0] expect_of(input exs_pipe_s q);
		if (q.addr_err)
			return {`EXS_VOFS_ADDR_ERR, q.in_slot ? q.branch_pc : q.inst_pc};
		if (q.in_slot && (q.undef_op || q.pc_change_op))
			return {`EXS_VOFS_SLOT, q.branch_target};
		if (q.undef_op)
			return {`EXS_VOFS_ILLEGAL, q.inst_pc};
		return {22'h0, q.trap_vec, 2'h0, q.next_pc};
	endfunction

	// Level an accepted interrupt leaves in the mask
	function automatic logic [3:0] exp_lvl(input exs_intr_s q);
		return (q.nmi || q.level > 5'h0f) ? 4'hf : q.level[3:0];
	endfunction

	// Bounded wait for the branch pulse
	task automatic land(input logic [31:0] epc, input logic [31:0] esp, input logic [3:0] m);
		for (int i = 0; i < 80 && load_pc !== 1'b1; i++)
			step(1);
		chk(32'(load_pc), 32'h1);
		chk(32'(load_sp), 32'h1);
		chk(new_pc, epc);
		chk(new_sp, esp);
		chk(vbase, 32'h0);
		chk(32'(mask), 32'(m));
		chk(sw_out, {sw[31:8], m, sw[3:0]});
	endtask

	task automatic reset_land();
		land(mem(`EXS_RESET_PC_ADDR), mem(`EXS_RESET_SP_ADDR), 4'hf);
		step(2);
	endtask

	initial begin
		seed = $urandom(32'hed60d572);
		{rst_in, pin_n, wdt_ov, wdt_en, dbg, retired, slow} = 8'h80;
		pipe = '0;
		intr = '0;
		sp = 32'h1000;
		sw = 32'hf0;
		step(5);
		rst_in = 1'b0;
		step(20);
		chk(32'(init & busy), 32'h1);
		pin_n = 1'b1;
		reset_land();
		for (int i = 0; i < 32; i++) begin
			slow = 2'($urandom);
			sp = ($urandom & 32'h00fffff0) + 32'h100;
			sw = $urandom | 32'hf0;
			p = {codes[i%8], 8'($urandom), $urandom, $urandom, $urandom, $urandom};
			e = expect_of(p);
			pipe = p;
			step(1);
			pipe = '0;
			if (p.addr_err) begin
				step(3);
				chk(32'(bus.req), 32'h0);
				retired = 1'b1;
				step(1);
				retired = 1'b0;
			end
			land(mem(e[63:32]), sp - 32'h8, 4'hf);
			chk(32'(mload), 32'h0);
			chk(wlog[1], sw);
			chk(wlog[0], e[31:0]);
			step(2);
		end
		for (int i = 0; i < 12; i++) begin
			slow = 2'($urandom);
			// Corner first: unclipped 16 from a maskable source, mask just below
			sw = (i == 0) ? 32'h000000e0 : $urandom;
			intr = {1'b1, i[0], (i == 0) ? 5'h10 : 5'($urandom % 17), $urandom & 32'h3fc};
			v = intr.vec_ofs;
			em = exp_lvl(intr);
			take = intr.nmi || em > sw[7:4];
			#1;
			chk(32'(iack), 32'(take));
			step(1);
			intr = '0;
			if (take) begin
				land(mem(v), sp - 32'h8, em);
				chk(32'(mload), 32'h1);
				chk(wlog[1], sw);
			end
			step(3);
			chk(32'(busy), 32'h0);
		end
		wdt_ov = 1'b1;
		step(8);
		chk(32'(busy), 32'h0);
		wdt_ov = 1'b0;
		wdt_en = 1'b1;
		step(2);
		wdt_ov = 1'b1;
		reset_land();
		wdt_ov = 1'b0;
		dbg = 1'b1;
		reset_land();
		dbg = 1'b0;
		// No wait states: the pin cuts in after the second push has begun
		slow = 2'h0;
		pipe = p;
		step(1);
		pipe = '0;
		step(1);
		pin_n = 1'b0;
		step(20);
		chk(32'(init & busy & ~bus.req), 32'h1);
		pin_n = 1'b1;
		reset_land();
		pin_n = 1'b0;
		wdt_ov = 1'b1;
		seen = 1'b0;
		repeat (20) begin
			step(1);
			seen |= clr;
		end
		chk(32'(seen), 32'h1);
		pin_n = 1'b1;
		wdt_ov = 1'b0;
		reset_land();
		finish_test();
	end
endmodule // cpu_exception_sequencer_test

`default_nettype wire
